// ==== hdl/scdu_pkg.sv ====
/*
 Constants for the duplex serial channel: register offsets, field positions,
 reset values, modes and engine states.
 Assumes a Wishbone slave with 32-bit data and byte addresses.
*/
// How it works
// - Full duplex clocked operation runs only while mode control register 1 bit 6 is set.
// - Clock output single buffer: a send write starts clock, shifts 8 in and out.
// - Next clocked frame waits for receive read and send write, either order.
// - Double buffered output: received byte moves to buffer 2; frame start moves send data.
// - Output clock stays stopped while send buffer empty or receive buffer full.
// - Clock input single send buffer: shift on external clock, interrupts at completion.
// - Clock input double buffered: next external clock sends buffer 1, receives simultaneously.
// - Overrun flagged when receive buffer 2 is unread at a frame's last bit.
// - Underrun flagged, with double buffering on, when send buffer 2 is empty as a new external frame starts.
// - Mode select 01 gives the 7-bit asynchronous transceiver.
// - Seven and eight bit modes add and check parity, even or odd selectable.
// - Asynchronous stop length follows the stop length select bit.
// - Mode select 10 gives the 8-bit asynchronous transceiver.
// - Mode select 11 gives the 9-bit asynchronous transceiver.
// - Ninth bit sent from mode control register 0 bit 7, received into control bit 7.
// - With wake filter on, only frames with ninth bit one are accepted.
// - On underrun the bit counter still runs and an all-ones byte is sent.
package scdu_pkg;
   localparam logic [7:0] A_DATA = 8'h00;
   localparam logic [7:0] A_MOD0 = 8'h04;
   localparam logic [7:0] A_MOD1 = 8'h08;
   localparam logic [7:0] A_MOD2 = 8'h0C;
   localparam logic [7:0] A_CR = 8'h10;
   localparam logic [7:0] A_BRG = 8'h14;
   localparam logic [7:0] A_EN = 8'h18;
   localparam int B_TX9 = 7;
   localparam int B_RXE = 5;
   localparam int B_WAKE = 4;
   localparam int B_SM = 2;
   localparam int B_DUPLEX = 6;
   localparam int B_OPEN_DRAIN = 1;
   localparam int B_CKO = 0;
   localparam int B_STOP2 = 4;
   localparam int B_DBL_BUF = 2;
   localparam int B_EVEN = 5;
   localparam int B_PAR_ON = 4;
   localparam int B_CHAN_EN = 0;
   localparam logic [7:0] R_MOD = 8'h00;
   localparam logic [15:0] R_BRG = 16'h0010;
   localparam logic [7:0] DUMMY = 8'hFF;
   typedef enum logic [1:0] {
      SM_CLK = 2'b00, SM_U7 = 2'b01, SM_U8 = 2'b10, SM_U9 = 2'b11
   } scdu_mode_t;
   typedef enum logic [1:0] {
      ST_IDLE = 2'b00, ST_ASYNC = 2'b01, ST_CKOUT = 2'b10, ST_CKIN = 2'b11
   } scdu_st_t;
endpackage : scdu_pkg

// ==== hdl/scdu_top.sv ====
/*
 Duplex serial channel: full-duplex clocked mode and 7/8/9-bit asynchronous
 modes behind a classic Wishbone slave.
 Assumes i_rxd and i_sclk are asynchronous pins; bus on i_mclk.
*/
`timescale 1ns/1ps
module scdu_top import scdu_pkg::*; #(
   parameter logic [15:0] BRG_RST = R_BRG
) (
   input wire logic i_mclk,
   input wire logic i_rst_n,
   input wire logic i_ce,
   input wire logic i_wb_cyc,
   input wire logic i_wb_stb,
   input wire logic i_wb_we,
   input wire logic [7:0] i_wb_adr,
   input wire logic [3:0] i_wb_sel,
   input wire logic [31:0] i_wb_dat,
   output logic [31:0] o_wb_dat,
   output logic o_wb_ack,
   input wire logic i_rxd,
   input wire logic i_sclk,
   output logic o_txd,
   output logic o_txd_oe,
   output logic o_sclk,
   output logic o_sclk_oe,
   output logic o_tx_irq,
   output logic o_rx_irq
);
   logic en_q, stop2_q, dbl_buf_q, even_q, par_on_q;
   logic [7:0] mod0_q, mod1_q, tb2_q, rb2_q, ck_rx_q;
   logic [15:0] brg_q, tmr_q, rx_tmr_q;
   logic tb2_full_q, rb2_full_q, rx_ninth_q, ovr_q, perr_q, ferr_q, und_q;
   logic [2:0] rxd_s, sck_s;
   scdu_st_t st_q;
   logic [11:0] tx_sh_q, tx_frame, rx_sh_q;
   logic [3:0] bits_q, dlen, tx_len, rx_last, rx_idx_q;
   logic sclk_q, ck_done_q, rx_act_q, as_done_q;
   logic acc, wr, wr_on, rd, wr_data, rd_data, rd_cr;
   logic clocked, async, ext, extbit, tick, as_go, co_go, ci_go, take;
   logic sck_fall, sck_rise, rx_fall, as_x, as_stop, as_par, wake_drop, put;
   logic [7:0] txd8, as_d, put_d;
   logic [31:0] rdat;
   scdu_mode_t sm;

   // Bus decode; one access per request, answered next cycle
   assign acc = i_ce & i_wb_cyc & i_wb_stb & ~o_wb_ack;
   assign wr = acc & i_wb_we & i_wb_sel[0];
   assign wr_on = wr & en_q; // Disabled channel keeps its settings
   assign rd = acc & ~i_wb_we;
   assign wr_data = wr_on & (i_wb_adr == A_DATA);
   assign rd_data = rd & (i_wb_adr == A_DATA);
   assign rd_cr = rd & (i_wb_adr == A_CR);

   // Mode decode
   assign sm = scdu_mode_t'(mod0_q[B_SM+:2]);
   assign clocked = en_q & (sm == SM_CLK) & mod1_q[B_DUPLEX];
   assign async = en_q & (sm != SM_CLK);
   assign dlen = (sm == SM_U7) ? 4'h7 : 4'h8;
   assign ext = par_on_q | (sm == SM_U9);
   assign sck_fall = sck_s[2] & ~sck_s[1];
   assign sck_rise = ~sck_s[2] & sck_s[1];
   assign rx_fall = rxd_s[2] & ~rxd_s[1];
   assign tick = (tmr_q == 16'h0000);

   // Transmit frame: start, data LSB first, parity or ninth bit, stops
   assign txd8 = (sm == SM_U7) ? {1'b0, tb2_q[6:0]} : tb2_q;
   assign extbit = (sm == SM_U9) ? mod0_q[B_TX9] : (even_q ? ^txd8 : ~^txd8);
   assign tx_len = 4'(dlen + {3'b000, ext} + 4'h2 + {3'b000, stop2_q});
   always_comb begin
      tx_frame = 12'hFFF;
      tx_frame[0] = 1'b0;
      for (int i = 0; i < 8; i++) begin
         if (4'(i) < dlen) begin
            tx_frame[i+1] = tb2_q[i];
         end
      end
      if (ext) begin
         tx_frame[4'(dlen + 4'h1)] = extbit;
      end
   end

   // Frame starts; output clock waits for send data and an empty receive slot
   assign as_go = (st_q == ST_IDLE) & async & tb2_full_q;
   assign co_go = (st_q == ST_IDLE) & clocked & mod1_q[B_CKO] & tb2_full_q
                  & ~rb2_full_q;
   assign ci_go = (st_q == ST_IDLE) & clocked & ~mod1_q[B_CKO] & sck_fall;
   assign take = as_go | co_go | (ci_go & tb2_full_q);

   // Configuration registers
   always_ff @(posedge i_mclk) begin
      if (!i_rst_n) begin
         en_q <= 1'b0;
         mod0_q <= R_MOD;
         mod1_q <= R_MOD;
         stop2_q <= 1'b0;
         dbl_buf_q <= 1'b0;
         even_q <= 1'b0;
         par_on_q <= 1'b0;
         brg_q <= BRG_RST;
      end else if (i_ce) begin
         if (wr && i_wb_adr == A_EN) begin
            en_q <= i_wb_dat[B_CHAN_EN];
         end
         if (wr_on) begin
            case (i_wb_adr)
               A_MOD0: mod0_q <= i_wb_dat[7:0];
               A_MOD1: mod1_q <= i_wb_dat[7:0];
               A_MOD2: begin
                  stop2_q <= i_wb_dat[B_STOP2];
                  dbl_buf_q <= i_wb_dat[B_DBL_BUF];
               end
               A_CR: begin
                  even_q <= i_wb_dat[B_EVEN];
                  par_on_q <= i_wb_dat[B_PAR_ON];
               end
               A_BRG: brg_q <= i_wb_dat[15:0];
               default: ;
            endcase
         end
      end
   end

   // Read mux; unmapped offsets read zero
   always_comb begin
      rdat = 32'h0000_0000;
      case (i_wb_adr)
         A_DATA: rdat[7:0] = rb2_q;
         A_MOD0: rdat[7:0] = mod0_q;
         A_MOD1: rdat[7:0] = mod1_q;
         A_MOD2: rdat[7:0] = {~tb2_full_q, rb2_full_q, 1'b0, stop2_q, 1'b0, dbl_buf_q, 2'b00};
         A_CR: rdat[7:0] = {rx_ninth_q, 1'b0, even_q, par_on_q, ovr_q, perr_q, ferr_q, und_q};
         A_BRG: rdat[15:0] = brg_q;
         A_EN: rdat[0] = en_q;
         default: ;
      endcase
   end

   // Bus answer: ack one cycle after the request, dropped the cycle after
   always_ff @(posedge i_mclk) begin
      if (!i_rst_n) begin
         o_wb_ack <= 1'b0;
         o_wb_dat <= 32'h0000_0000;
      end else if (i_ce) begin
         o_wb_ack <= acc;
         if (rd) begin
            o_wb_dat <= rdat;
         end
      end
   end

   // Pin synchronisers; only the second and third stages are looked at
   always_ff @(posedge i_mclk) begin
      if (!i_rst_n) begin
         rxd_s <= 3'h7;
         sck_s <= 3'h7;
      end else if (i_ce) begin
         rxd_s <= {rxd_s[1:0], i_rxd};
         sck_s <= {sck_s[1:0], i_sclk};
      end
   end

   // Send buffer 2; a write in the same cycle as a take survives
   always_ff @(posedge i_mclk) begin
      if (!i_rst_n) begin
         tb2_q <= 8'h00;
         tb2_full_q <= 1'b0;
      end else if (i_ce) begin
         if (wr_data) begin
            tb2_q <= i_wb_dat[7:0];
            tb2_full_q <= 1'b1;
         end else if (take) begin
            tb2_full_q <= 1'b0;
         end
      end
   end

   // Transmit and clocked-mode engine
   always_ff @(posedge i_mclk) begin
      if (!i_rst_n) begin
         st_q <= ST_IDLE;
         tx_sh_q <= 12'hFFF;
         bits_q <= 4'h0;
         tmr_q <= 16'h0000;
         sclk_q <= 1'b1;
         ck_rx_q <= 8'h00;
         ck_done_q <= 1'b0;
         o_tx_irq <= 1'b0;
      end else if (i_ce) begin
         ck_done_q <= 1'b0;
         o_tx_irq <= 1'b0;
         if (!tick) begin
            tmr_q <= 16'(tmr_q - 16'h0001);
         end
         case (st_q)
            ST_IDLE: begin
               sclk_q <= 1'b1;
               if (as_go) begin
                  tx_sh_q <= tx_frame;
                  bits_q <= tx_len;
                  tmr_q <= 16'(brg_q - 16'h0001);
                  st_q <= ST_ASYNC;
               end else if (co_go) begin
                  tx_sh_q <= {4'hF, tb2_q};
                  bits_q <= 4'h8;
                  tmr_q <= 16'(brg_q - 16'h0001);
                  sclk_q <= 1'b0;
                  st_q <= ST_CKOUT;
               end else if (ci_go) begin
                  // Empty buffer sends all ones and still counts bits
                  tx_sh_q <= {4'hF, tb2_full_q ? tb2_q : DUMMY};
                  bits_q <= 4'h8;
                  st_q <= ST_CKIN;
               end
            end
            ST_ASYNC: begin
               if (tick) begin
                  tx_sh_q <= {1'b1, tx_sh_q[11:1]};
                  tmr_q <= 16'(brg_q - 16'h0001);
                  bits_q <= 4'(bits_q - 4'h1);
                  if (bits_q == 4'h1) begin
                     o_tx_irq <= 1'b1;
                     st_q <= ST_IDLE;
                  end
               end
            end
            ST_CKOUT: begin
               if (tick) begin
                  tmr_q <= 16'(brg_q - 16'h0001);
                  if (!sclk_q) begin
                     sclk_q <= 1'b1; // Sample on the rising edge
                     ck_rx_q <= {rxd_s[1], ck_rx_q[7:1]};
                     bits_q <= 4'(bits_q - 4'h1);
                  end else if (bits_q == 4'h0) begin
                     ck_done_q <= 1'b1;
                     o_tx_irq <= 1'b1;
                     st_q <= ST_IDLE; // Clock stops here
                  end else begin
                     sclk_q <= 1'b0;
                     tx_sh_q <= {1'b1, tx_sh_q[11:1]};
                  end
               end
            end
            ST_CKIN: begin
               if (sck_rise) begin
                  ck_rx_q <= {rxd_s[1], ck_rx_q[7:1]};
                  bits_q <= 4'(bits_q - 4'h1);
                  if (bits_q == 4'h1) begin
                     ck_done_q <= 1'b1;
                     o_tx_irq <= 1'b1;
                     st_q <= ST_IDLE;
                  end
               end else if (sck_fall) begin
                  tx_sh_q <= {1'b1, tx_sh_q[11:1]};
               end
            end
            default: st_q <= ST_IDLE;
         endcase
      end
   end

   // Asynchronous receiver: mid-bit sampling, bits stored by index
   assign rx_last = 4'(dlen + {3'b000, ext} + 4'h1);
   always_ff @(posedge i_mclk) begin
      if (!i_rst_n) begin
         rx_act_q <= 1'b0;
         rx_idx_q <= 4'h0;
         rx_tmr_q <= 16'h0000;
         rx_sh_q <= 12'hFFF;
         as_done_q <= 1'b0;
      end else if (i_ce) begin
         as_done_q <= 1'b0;
         if (!rx_act_q) begin
            if (async && mod0_q[B_RXE] && rx_fall) begin
               rx_act_q <= 1'b1;
               rx_idx_q <= 4'h0;
               rx_tmr_q <= {1'b0, brg_q[15:1]};
            end
         end else if (rx_tmr_q == 16'h0000) begin
            rx_tmr_q <= 16'(brg_q - 16'h0001);
            rx_sh_q[rx_idx_q] <= rxd_s[1];
            rx_idx_q <= 4'(rx_idx_q + 4'h1);
            if (rx_idx_q == 4'h0 && rxd_s[1]) begin
               rx_act_q <= 1'b0; // Start bit was a glitch
            end else if (rx_idx_q == rx_last) begin
               rx_act_q <= 1'b0;
               as_done_q <= 1'b1;
            end
         end else begin
            rx_tmr_q <= 16'(rx_tmr_q - 16'h0001);
         end
      end
   end

   // Received frame decode and wake-up filter
   assign as_d = (sm == SM_U7) ? {1'b0, rx_sh_q[7:1]} : rx_sh_q[8:1];
   assign as_x = rx_sh_q[4'(dlen + 4'h1)];
   assign as_stop = rx_sh_q[rx_last];
   assign as_par = even_q ? ^as_d : ~^as_d;
   assign wake_drop = (sm == SM_U9) & mod0_q[B_WAKE] & ~as_x;
   assign put = ck_done_q | (as_done_q & ~wake_drop);
   assign put_d = ck_done_q ? ck_rx_q : as_d;

   // Receive buffer 2 and error flags; a set beats a same-cycle clear
   always_ff @(posedge i_mclk) begin
      if (!i_rst_n) begin
         rb2_q <= 8'h00;
         rb2_full_q <= 1'b0;
         rx_ninth_q <= 1'b0;
         ovr_q <= 1'b0;
         perr_q <= 1'b0;
         ferr_q <= 1'b0;
         und_q <= 1'b0;
         o_rx_irq <= 1'b0;
      end else if (i_ce) begin
         o_rx_irq <= 1'b0;
         if (put && !rb2_full_q) begin
            rb2_q <= put_d;
            rb2_full_q <= 1'b1;
            o_rx_irq <= 1'b1;
            if (as_done_q && sm == SM_U9) begin
               rx_ninth_q <= as_x;
            end
         end else if (rd_data) begin
            rb2_full_q <= 1'b0;
         end
         if (put && rb2_full_q) begin
            ovr_q <= 1'b1;
         end else if (rd_cr) begin
            ovr_q <= 1'b0;
         end
         if (as_done_q && !wake_drop && par_on_q && sm != SM_U9 && as_x != as_par) begin
            perr_q <= 1'b1;
         end else if (rd_cr) begin
            perr_q <= 1'b0;
         end
         if (as_done_q && !wake_drop && !as_stop) begin
            ferr_q <= 1'b1;
         end else if (rd_cr) begin
            ferr_q <= 1'b0;
         end
         if (ci_go && !tb2_full_q && dbl_buf_q) begin
            und_q <= 1'b1;
         end else if (rd_cr) begin
            und_q <= 1'b0;
         end
      end
   end

   // Pin drivers; open-drain releases the line for a one
   always_ff @(posedge i_mclk) begin
      if (!i_rst_n) begin
         o_txd <= 1'b1;
         o_txd_oe <= 1'b0;
         o_sclk <= 1'b1;
         o_sclk_oe <= 1'b0;
      end else if (i_ce) begin
         o_txd <= (st_q == ST_IDLE) | tx_sh_q[0];
         o_txd_oe <= en_q & (~mod1_q[B_OPEN_DRAIN] | ((st_q != ST_IDLE) & ~tx_sh_q[0]));
         o_sclk <= sclk_q;
         o_sclk_oe <= clocked & mod1_q[B_CKO];
      end
   end

   // Checks
   default clocking cb @(posedge i_mclk);
   endclocking
   default disable iff (!i_rst_n);

   a_ack_single: assert property (i_ce && o_wb_ack |=> !o_wb_ack)
      else $error("ack held longer than one cycle");
   a_duplex_gate: assert property (
      i_ce && st_q == ST_IDLE && !mod1_q[B_DUPLEX] |=> st_q != ST_CKOUT && st_q != ST_CKIN)
      else $error("clocked frame without duplex bit");
   a_ckout_start: assert property (
      i_ce && co_go |=> st_q == ST_CKOUT && bits_q == 4'h8 && !sclk_q)
      else $error("output clock frame did not start");
   a_wait_read: assert property (
      i_ce && st_q == ST_IDLE && rb2_full_q |=> st_q != ST_CKOUT)
      else $error("clock ran with receive buffer full");
   a_async_mode: assert property (
      i_ce && as_go |=> st_q == ST_ASYNC && bits_q == $past(tx_len))
      else $error("asynchronous frame length wrong");
   a_lsb_first: assert property (
      i_ce && as_go |=> tx_sh_q[0] == 1'b0 && tx_sh_q[1] == $past(tb2_q[0]))
      else $error("first data bit not the lsb");
   a_overrun_flag: assert property (
      i_ce && ck_done_q && rb2_full_q |=> ovr_q && !o_rx_irq)
      else $error("overrun not flagged");
   a_underrun_dummy: assert property (
      i_ce && ci_go && !tb2_full_q && dbl_buf_q |=> und_q && tx_sh_q[7:0] == DUMMY)
      else $error("underrun did not send dummy byte");
   a_wake_drop: assert property (
      i_ce && as_done_q && wake_drop |=> !o_rx_irq)
      else $error("wake filter passed a data frame");
   a_rx_move: assert property (
      i_ce && put && !rb2_full_q |=> o_rx_irq && rb2_full_q)
      else $error("received byte not moved to buffer 2");

   c_ckout_done: cover property (st_q == ST_CKOUT ##[1:400] ck_done_q);
   c_ckin_under: cover property (ci_go && !tb2_full_q && dbl_buf_q);
   c_async_rx: cover property (as_done_q && !wake_drop);
   c_wake_drop: cover property (as_done_q && wake_drop);
endmodule : scdu_top

// ==== dv/scdu_peer.sv ====
/*
 Remote serial peer: sends asynchronous frames, answers the output shift
 clock as a slave, and makes its own shift clock for clock-input frames.
 Assumes the bench calls its tasks and sets arm and sbyte directly.
*/
`timescale 1ns/1ps
module scdu_peer #(
   parameter int PER = 16
) (
   input wire logic i_mclk,
   input wire logic i_txd,
   input wire logic i_sclk,
   output logic o_rxd,
   output logic o_sclk
);
   logic arm = 1'b0;
   logic prev = 1'b1;
   logic [7:0] sbyte = 8'h00;
   logic [7:0] got = 8'h00;
   logic [2:0] idx = 3'h0;
   // Both lines idle high, as an unused link would
   initial begin
      o_rxd = 1'b1;
      o_sclk = 1'b1;
   end
   // Slave to the output clock: drive on fall, take on rise
   always @(posedge i_mclk) begin
      prev <= i_sclk;
      if (arm && prev && !i_sclk) begin
         o_rxd <= sbyte[idx];
      end
      if (arm && !prev && i_sclk) begin
         got[idx] <= i_txd;
         idx <= idx + 3'h1;
      end
   end
   // Async frame, start bit first, line back to idle after the last stop
   task automatic send(input logic [11:0] f, input int n);
      for (int i = 0; i < n; i++) begin
         o_rxd <= f[i];
         repeat (PER) @(posedge i_mclk);
      end
      o_rxd <= 1'b1;
   endtask : send
   // Clocked frame, 160 ns shift clock paced by i_mclk; called just after a rising edge
   // Line left at the inverse of the last data bit afterwards so stale bits show
   task automatic frame(input logic [7:0] d);
      for (int i = 0; i < 8; i++) begin
         o_sclk <= 1'b0;
         o_rxd <= d[i];
         repeat (8) @(posedge i_mclk);
         got[i] = i_txd;
         o_sclk <= 1'b1;
         repeat (8) @(posedge i_mclk);
      end
      o_rxd <= ~d[7];
   endtask : frame
endmodule : scdu_peer

// ==== dv/testbench.sv ====
/*
 Self-checking bench for the duplex serial channel: bus access, async
 frames both ways, wake filter, clocked output and clocked input modes.
 Assumes the design answers every bus request with a one-cycle ack.
*/
`timescale 1ns/1ps
module testbench import scdu_pkg::*;;
   localparam int BRG = 16;
   logic i_mclk = 1'b0;
   logic i_rst_n = 1'b0;
   logic cyc = 1'b0, stb = 1'b0, we = 1'b0;
   logic [7:0] adr = 8'h00;
   logic [31:0] dat = 32'h0, q, rdat;
   logic ack, txd, txd_oe, sclk, sclk_oe, tx_irq, rx_irq, rxd, sclk_in;
   int num_errors = 0;
   int checked = 0;
   always #5 i_mclk = ~i_mclk;
   scdu_top dut_u (.i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_ce(1'b1), .i_wb_cyc(cyc),
      .i_wb_stb(stb), .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(4'hF), .i_wb_dat(dat),
      .o_wb_dat(rdat), .o_wb_ack(ack), .i_rxd(rxd), .i_sclk(sclk_in), .o_txd(txd),
      .o_txd_oe(txd_oe), .o_sclk(sclk), .o_sclk_oe(sclk_oe), .o_tx_irq(tx_irq),
      .o_rx_irq(rx_irq));
   scdu_peer peer_u (.i_mclk(i_mclk), .i_txd(txd), .i_sclk(sclk), .o_rxd(rxd),
      .o_sclk(sclk_in));
   // Verdict and exit, also reached when a wait runs out
   task automatic end_sim();
      if (num_errors == 0 && checked > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : end_sim
   task automatic give_up();
      num_errors++;
      end_sim();
   endtask : give_up
   task automatic chk(input logic [7:0] s, input logic [7:0] e);
      checked++;
      if (s !== e) begin
         num_errors++;
         $display("BAD t=%0t seen=%h exp=%h", $time, s, e);
      end
   endtask : chk
   // Classic single cycle: hold everything until ack is seen at an edge
   task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
      int n;
      @(posedge i_mclk);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      dat <= {24'h0, d};
      n = 0;
      do begin
         @(posedge i_mclk);
         n++;
      end while (ack !== 1'b1 && n < 20);
      if (ack !== 1'b1) give_up();
      q = rdat;
      cyc <= 1'b0;
      stb <= 1'b0;
   endtask : bus
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      bus(1'b1, a, d);
   endtask : wr
   task automatic rdc(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
      bus(1'b0, a, 8'h00);
      chk(q[7:0] & m, e);
   endtask : rdc
   // Bounded watch for an interrupt pulse; absence may be the expected outcome
   task automatic waitirq(input logic rx, input logic exp, input int lim);
      logic got;
      got = 1'b0;
      for (int i = 0; i < lim && got !== 1'b1; i++) begin
         @(posedge i_mclk);
         got = rx ? rx_irq : tx_irq;
      end
      chk(8'(got), 8'(exp));
      if (exp && got !== 1'b1) give_up();
   endtask : waitirq
   // Expected async frame bits, start first; returns the bit count
   function automatic int mkframe(input logic [1:0] m, input logic [7:0] d,
      input logic par, input logic ev, input logic n9, input logic sb, output logic [11:0] f);
      int n;
      logic [7:0] v;
      v = (m == 2'b01) ? {1'b0, d[6:0]} : d;
      f = 12'hFFF;
      f[0] = 1'b0;
      f[8:1] = v;
      n = (m == 2'b01) ? 8 : 9;
      if (m == 2'b11) begin
         f[n] = n9;
         n++;
      end else if (par) begin
         f[n] = ev ? ^v : ~^v;
         n++;
      end
      f[n] = 1'b1;
      f[n + 1] = 1'b1;
      return n + 1 + int'(sb);
   endfunction : mkframe
   task automatic txmon(input logic [11:0] f, input int n);
      int w;
      w = 0;
      while (txd !== 1'b0 && w < 60) begin
         @(posedge i_mclk);
         w++;
      end
      if (txd !== 1'b0) give_up();
      repeat (BRG / 2) @(posedge i_mclk);
      for (int i = 0; i < n; i++) begin
         chk(8'(txd), 8'(f[i]));
         repeat (BRG) @(posedge i_mclk);
      end
   endtask : txmon
   // Main sequence
   initial begin
      logic [11:0] f;
      int n, lo;
      logic [7:0] d, s1, s2;
      logic [1:0] m;
      logic par, ev, sb, n9, bad;
      void'($urandom(18));
      repeat (6) @(posedge i_mclk);
      i_rst_n <= 1'b1;
      @(posedge i_mclk);
      chk({4'h0, txd, sclk, txd_oe, sclk_oe}, 8'h0C);
      wr(A_MOD0, 8'h0C);
      rdc(A_MOD0, 8'hFF, 8'h00);
      wr(A_EN, 8'h01);
      rdc(8'h1C, 8'hFF, 8'h00);
      wr(A_BRG, 8'h10);
      // Each async mode twice, random settings, out and back in
      for (int k = 0; k < 6; k++) begin
         m = 2'(k / 2 + 1);
         d = (k == 0) ? 8'h80 : 8'($urandom);
         par = (m != 2'b11) ? 1'($urandom) : 1'b0;
         ev = 1'($urandom);
         sb = 1'($urandom);
         n9 = 1'($urandom);
         bad = par & 1'($urandom);
         n = mkframe(m, d, par, ev, n9, sb, f);
         wr(A_CR, {2'b00, ev, par, 4'h0});
         wr(A_MOD2, {3'b000, sb, 4'h0});
         wr(A_MOD0, {n9, 2'b01, 1'b0, m, 2'b00});
         wr(A_DATA, d);
         // Transmit interrupt must come within 400 cycles of the send write
         fork
            txmon(f, n);
            waitirq(1'b0, 1'b1, 400);
         join
         f[(m == 2'b01) ? 8 : 9] ^= bad;
         fork
            peer_u.send(f, n);
            waitirq(1'b1, 1'b1, 400);
         join
         rdc(A_CR, 8'h86, {(m == 2'b11) & n9, 4'h0, bad, 2'b00});
         rdc(A_DATA, (m == 2'b01) ? 8'h7F : 8'hFF, d & ((m == 2'b01) ? 8'h7F : 8'hFF));
      end
      // Multi-drop slave: data ignored, select taken, then data after filter off
      wr(A_CR, 8'h00);
      wr(A_MOD1, 8'h02);
      @(posedge i_mclk);
      chk(8'(txd_oe), 8'h00);
      for (int j = 0; j < 3; j++) begin
         d = 8'($urandom);
         wr(A_MOD0, (j == 2) ? 8'h2C : 8'h3C);
         n = mkframe(2'b11, d, 1'b0, 1'b0, j == 1, 1'b0, f);
         fork
            peer_u.send(f, n);
            waitirq(1'b1, j != 0, 300);
         join
         if (j != 0) rdc(A_DATA, 8'hFF, d);
      end
      // Clock output duplex; both orders of read and write before the next frame
      wr(A_MOD1, 8'h41);
      wr(A_MOD0, 8'h20);
      wr(A_BRG, 8'h08);
      chk(8'(sclk_oe), 8'h01);
      for (int b = 0; b < 2; b++) begin
         wr(A_MOD2, b ? 8'h04 : 8'h00);
         s1 = 8'($urandom);
         d = 8'($urandom);
         peer_u.sbyte = s1;
         peer_u.idx = 3'h0;
         peer_u.arm = 1'b1;
         wr(A_DATA, d);
         waitirq(1'b1, 1'b1, 400);
         chk(peer_u.got, d);
         s2 = 8'($urandom);
         d = 8'($urandom);
         peer_u.sbyte = s2;
         if (b) wr(A_DATA, d);
         else rdc(A_DATA, 8'hFF, s1);
         lo = 0;
         repeat (40) begin
            @(posedge i_mclk);
            lo += int'(sclk !== 1'b1);
         end
         chk(8'(lo), 8'h00);
         if (b) rdc(A_DATA, 8'hFF, s1);
         else wr(A_DATA, d);
         waitirq(1'b1, 1'b1, 400);
         rdc(A_DATA, 8'hFF, s2);
         chk(peer_u.got, d);
      end
      // Clock input, double buffered: normal, underrun, then overrun
      peer_u.arm = 1'b0;
      wr(A_MOD1, 8'h40);
      wr(A_MOD2, 8'h04);
      for (int j = 0; j < 3; j++) begin
         d = 8'($urandom);
         s1 = 8'($urandom);
         if (j == 0) wr(A_DATA, d);
         if (j < 2) begin
            fork
               peer_u.frame(s1);
               waitirq(1'b1, 1'b1, 400);
            join
         end else begin
            peer_u.frame(s1);
            repeat (8) @(posedge i_mclk);
         end
         chk(peer_u.got, (j == 0) ? d : 8'hFF);
         rdc(A_CR, 8'h0F, {4'h0, j == 2, 2'b00, j != 0});
         if (j == 0) rdc(A_DATA, 8'hFF, s1);
         if (j == 1) s2 = s1;
      end
      rdc(A_DATA, 8'hFF, s2);
      end_sim();
   end
endmodule : testbench
